// file: alert_overheat_map.vh
`ifndef ALERT_OVERHEAT_MAP_VH
`define ALERT_OVERHEAT_MAP_VH

// ==========================================================
// Register offsets
`define ADDR_STATUS_FIRST 8'h41
`define ADDR_STATUS_SECOND 8'h42
`define ADDR_MASK_FIRST 8'h74
`define ADDR_MASK_SECOND 8'h75
`define ADDR_CONFIG_THREE 8'h78
`define ADDR_OVERHEAT_TIMER 8'h79
`define ADDR_OVERHEAT_LIMIT 8'h7a
`define ADDR_CONFIG_FOUR 8'h7d

// ==========================================================
// Field positions
`define SUMMARY_BIT 7
`define FOURTH_TACH_BIT 5
`define CFG3_ALERT_BIT 0
`define CFG3_OVERHEAT_EN_BIT 1
`define CFG3_FULL_SPEED_ON_OVERHEAT_BIT 2
`define CFG4_LOW_RAIL_ALERT_BIT 0
`define CFG4_OVERHEAT_SEL_BIT 1

// ==========================================================
// Reset values, full duty and timer full scale
`define MASK_RESET 8'h00
`define CONFIG_RESET 8'h00
`define LIMIT_RESET 8'h00
`define FULL_DUTY 8'hff
`define TIMER_FULL 8'hff

// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define OVERHEAT_LSB_NS 22760000
`define OVERHEAT_TICK_CYCLES (`OVERHEAT_LSB_NS / `CLK_PERIOD_NS)
`define TICK_COUNT_WIDTH 20

`endif

// file: overheat_timer.v
`timescale 1ns/1ps
`default_nettype none

module overheat_timer #(
    parameter TICK_CYCLES = 910400,
    parameter COUNT_WIDTH = 20
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_asserted,
    input wire i_clear,
    output wire [7:0] o_value
);

`include "alert_overheat_map.vh"

localparam integer tick_last_full = TICK_CYCLES - 1;
localparam [COUNT_WIDTH-1:0] tick_last = tick_last_full[COUNT_WIDTH-1:0];

reg [COUNT_WIDTH-1:0] cycle_count;
reg [7:0] ticks;
reg seen;

// ==========================================================
// Cumulative assertion time
always @(posedge i_clk or posedge i_reset)
begin
    if (i_reset)
    begin
        cycle_count <= {COUNT_WIDTH{1'b0}};
        ticks <= 8'h00;
        seen <= 1'b0;
    end
    else if (i_clear)
    begin
        cycle_count <= {COUNT_WIDTH{1'b0}};
        ticks <= 8'h00;
        seen <= i_asserted;
    end
    else if (i_asserted && ticks != `TIMER_FULL)
    begin
        seen <= 1'b1;
        if (cycle_count == tick_last)
        begin
            cycle_count <= {COUNT_WIDTH{1'b0}};
            ticks <= ticks + 8'h01;
        end
        else
        begin
            cycle_count <= cycle_count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

// Bit 0 marks any assertion until the second full step
assign o_value = (ticks == 8'h00 && seen) ? 8'h01 : ticks;

endmodule
`default_nettype wire

// file: alert_overheat_ctrl.v
// What this block does
// - Mask bits gate only the alert; status bits still set normally.
// - First mask bits 7..0 gate summary, remote2, local, remote1, 5V, supply, core, 2.5V.
// - Second mask bits 7..0 gate diode2, diode1, fourth_tach_fail, third_tach_fail, second_tach_fail, first_tach_fail, overtemp, 12V.
// - With overheat enabled on either pin, second mask bit 5 gates timer event.
// - Alert output disabled after reset; shared pins keep other functions.
// - Configuration three bit 0 turns its shared pin into alert output.
// - Configuration four bit 0 turns low-rail input pin into alert output.
// - Overheat pin works only while configuration three bit 1 is set.
// - Configuration four bit 1 picks 5V pin or tach pin, never both.
// - Full_speed_on_overheat bit forces running fans to full duty while overheat held low.
// - Full_speed_on_overheat leaves stopped fans alone: zero manual duty or below start temperature.
// - Timer counts only during assertion, holding value between assertions.
// - Timer accumulates until read clears it, saturating at full scale.
// - Timer is eight bits; bit 0 sets on first assertion after clear.
// - Past 45.52 ms bit 1 sets, bit 0 clears; LSB weighs 22.76 ms.
// - Timer read during assertion clears, sets bit 0, counts again from zero.
// - Limit 0x00 and read during assertion sets second status bit 5 again.
// - Status bits stick until read after the condition has gone.
// - Alert stays low while unmasked fault persists and until status read.
// - First status bit 7 reads one while any second status bit set.
// - Timer above limit sets second status bit 5 and alerts unless masked.
`timescale 1ns/1ps
`default_nettype none
`include "alert_overheat_map.vh"

module alert_overheat_ctrl #(
    parameter FAN_COUNT = 3,
    parameter TICK_CYCLES = `OVERHEAT_TICK_CYCLES,
    parameter TICK_WIDTH = `TICK_COUNT_WIDTH
) (
    input wire I_CLK,
    input wire I_RESET,
    input wire [7:0] I_REG_ADDR,
    input wire I_REG_WR,
    input wire [7:0] I_REG_WDATA,
    input wire I_REG_RD,
    output reg [7:0] O_REG_RDATA,
    input wire [6:0] I_FAULT_FIRST,
    input wire [7:0] I_FAULT_SECOND,
    input wire I_FOURTH_SPEED_INPUT,
    input wire I_FIVE_VOLT_PIN,
    input wire [8*FAN_COUNT-1:0] I_FAN_DUTY,
    input wire [FAN_COUNT-1:0] I_FAN_AUTO_MODE,
    input wire [FAN_COUNT-1:0] I_FAN_BELOW_START,
    output wire [8*FAN_COUNT-1:0] O_FAN_DUTY,
    output wire O_ALERT_PIN_OUT,
    output reg O_ALERT_PIN_OE,
    output wire O_LOW_RAIL_PIN_OUT,
    output reg O_LOW_RAIL_PIN_OE,
    output reg O_OVERHEAT_ON_TACH_PIN,
    output reg O_OVERHEAT_ON_FIVE_VOLT_PIN,
    output reg O_OVERHEAT_ACTIVE
);

reg [7:0] interrupt_mask_first;
reg [7:0] interrupt_mask_second;
reg [7:0] configuration_three;
reg [7:0] overheat_time_limit;
reg [7:0] configuration_four;
reg [6:0] status_first;
reg [7:0] status_second;
reg [2:0] tach_sync;
reg [2:0] five_sync;
reg tach_level;
reg five_level;

wire [7:0] overheat_assertion_timer;
wire wr_hit;
wire rd_hit;
wire overheat_enable;
wire overheat_select;
wire overheat_pin_low;
wire overheat_asserted;
wire timer_over_limit;
wire [7:0] second_source;
wire [7:0] status_first_view;
wire second_alert;
wire first_alert;
wire any_alert;
wire [6:0] next_status_first;
wire [7:0] next_status_second;

assign wr_hit = I_REG_WR;
assign rd_hit = I_REG_RD;

// ==========================================================
// Register writes
always @(posedge I_CLK or posedge I_RESET)
begin
    if (I_RESET)
    begin
        interrupt_mask_first <= `MASK_RESET;
        interrupt_mask_second <= `MASK_RESET;
        configuration_three <= `CONFIG_RESET;
        overheat_time_limit <= `LIMIT_RESET;
        configuration_four <= `CONFIG_RESET;
    end
    else if (wr_hit)
    begin
        case (I_REG_ADDR)
            `ADDR_MASK_FIRST:
            begin
                interrupt_mask_first <= I_REG_WDATA;
            end
            `ADDR_MASK_SECOND:
            begin
                interrupt_mask_second <= I_REG_WDATA;
            end
            `ADDR_CONFIG_THREE:
            begin
                configuration_three <= I_REG_WDATA;
            end
            `ADDR_OVERHEAT_LIMIT:
            begin
                overheat_time_limit <= I_REG_WDATA;
            end
            `ADDR_CONFIG_FOUR:
            begin
                configuration_four <= I_REG_WDATA;
            end
            default:
            begin
                interrupt_mask_first <= interrupt_mask_first;
            end
        endcase
    end
end

// ==========================================================
// Overheat pin sampling, active low
always @(posedge I_CLK or posedge I_RESET)
begin
    if (I_RESET)
    begin
        tach_sync <= 3'h7;
        five_sync <= 3'h7;
        tach_level <= 1'b1;
        five_level <= 1'b1;
    end
    else
    begin
        tach_sync <= {tach_sync[1:0], I_FOURTH_SPEED_INPUT};
        five_sync <= {five_sync[1:0], I_FIVE_VOLT_PIN};
        if (tach_sync[1] == tach_sync[2])
        begin
            tach_level <= tach_sync[2];
        end
        if (five_sync[1] == five_sync[2])
        begin
            five_level <= five_sync[2];
        end
    end
end

assign overheat_enable = configuration_three[`CFG3_OVERHEAT_EN_BIT];
assign overheat_select = configuration_four[`CFG4_OVERHEAT_SEL_BIT];
assign overheat_pin_low = overheat_select ? ~five_level : ~tach_level;
assign overheat_asserted = overheat_enable & overheat_pin_low;

// ==========================================================
// Assertion timer, cleared by reading it
overheat_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .COUNT_WIDTH(TICK_WIDTH)
) u_timer (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_asserted(overheat_asserted),
    .i_clear(rd_hit && I_REG_ADDR == `ADDR_OVERHEAT_TIMER),
    .o_value(overheat_assertion_timer)
);

assign timer_over_limit = overheat_enable && (overheat_assertion_timer > overheat_time_limit);

// ==========================================================
// Sticky status
assign second_source = overheat_enable
    ? {I_FAULT_SECOND[7:6], timer_over_limit, I_FAULT_SECOND[4:0]}
    : I_FAULT_SECOND;

// Reading clears only what is no longer faulty; a new fault wins
assign next_status_first = (rd_hit && I_REG_ADDR == `ADDR_STATUS_FIRST)
    ? I_FAULT_FIRST
    : (status_first | I_FAULT_FIRST);
assign next_status_second = (rd_hit && I_REG_ADDR == `ADDR_STATUS_SECOND)
    ? second_source
    : (status_second | second_source);

always @(posedge I_CLK or posedge I_RESET)
begin
    if (I_RESET)
    begin
        status_first <= 7'h00;
        status_second <= 8'h00;
    end
    else
    begin
        status_first <= next_status_first;
        status_second <= next_status_second;
    end
end

assign status_first_view = {|status_second, status_first};

// ==========================================================
// Alert generation
assign first_alert = |(status_first & ~interrupt_mask_first[6:0]);
assign second_alert = |(status_second & ~interrupt_mask_second)
    & ~interrupt_mask_first[`SUMMARY_BIT];
assign any_alert = first_alert | second_alert;

always @(posedge I_CLK or posedge I_RESET)
begin
    if (I_RESET)
    begin
        O_ALERT_PIN_OE <= 1'b0;
        O_LOW_RAIL_PIN_OE <= 1'b0;
        O_OVERHEAT_ON_TACH_PIN <= 1'b0;
        O_OVERHEAT_ON_FIVE_VOLT_PIN <= 1'b0;
        O_OVERHEAT_ACTIVE <= 1'b0;
    end
    else
    begin
        O_ALERT_PIN_OE <= configuration_three[`CFG3_ALERT_BIT] & any_alert;
        O_LOW_RAIL_PIN_OE <= configuration_four[`CFG4_LOW_RAIL_ALERT_BIT] & any_alert;
        O_OVERHEAT_ON_TACH_PIN <= overheat_enable & ~overheat_select;
        O_OVERHEAT_ON_FIVE_VOLT_PIN <= overheat_enable & overheat_select;
        O_OVERHEAT_ACTIVE <= overheat_asserted;
    end
end

// Open drain: pulls low only while enabled
assign O_ALERT_PIN_OUT = 1'b0;
assign O_LOW_RAIL_PIN_OUT = 1'b0;

// ==========================================================
// Fan full_speed_on_overheat on overheat
genvar fan;
generate
    for (fan = 0; fan < FAN_COUNT; fan = fan + 1)
    begin : g_fan
        wire [7:0] duty;
        wire running;
        reg [7:0] driven;
        assign duty = I_FAN_DUTY[8*fan+7:8*fan];
        assign running = I_FAN_AUTO_MODE[fan] ? ~I_FAN_BELOW_START[fan] : (duty != 8'h00);
        assign O_FAN_DUTY[8*fan+7:8*fan] = driven;
        always @(posedge I_CLK or posedge I_RESET)
        begin
            if (I_RESET)
            begin
                driven <= 8'h00;
            end
            else if (configuration_three[`CFG3_FULL_SPEED_ON_OVERHEAT_BIT] && overheat_asserted && running)
            begin
                driven <= `FULL_DUTY;
            end
            else
            begin
                driven <= duty;
            end
        end
    end
endgenerate

// ==========================================================
// Register reads
always @(posedge I_CLK or posedge I_RESET)
begin
    if (I_RESET)
    begin
        O_REG_RDATA <= 8'h00;
    end
    else if (rd_hit)
    begin
        case (I_REG_ADDR)
            `ADDR_STATUS_FIRST:
            begin
                O_REG_RDATA <= status_first_view;
            end
            `ADDR_STATUS_SECOND:
            begin
                O_REG_RDATA <= status_second;
            end
            `ADDR_MASK_FIRST:
            begin
                O_REG_RDATA <= interrupt_mask_first;
            end
            `ADDR_MASK_SECOND:
            begin
                O_REG_RDATA <= interrupt_mask_second;
            end
            `ADDR_CONFIG_THREE:
            begin
                O_REG_RDATA <= configuration_three;
            end
            `ADDR_OVERHEAT_TIMER:
            begin
                O_REG_RDATA <= overheat_assertion_timer;
            end
            `ADDR_OVERHEAT_LIMIT:
            begin
                O_REG_RDATA <= overheat_time_limit;
            end
            `ADDR_CONFIG_FOUR:
            begin
                O_REG_RDATA <= configuration_four;
            end
            default:
            begin
                O_REG_RDATA <= 8'h00;
            end
        endcase
    end
end

endmodule
`default_nettype wire

// file: alert_overheat_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module alert_overheat_ctrl_chk #(
    parameter FAN_COUNT = 3
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [6:0] I_FAULT_FIRST,
    input wire logic [8*FAN_COUNT-1:0] I_FAN_DUTY,
    input wire logic [FAN_COUNT-1:0] I_FAN_AUTO_MODE,
    input wire logic [8*FAN_COUNT-1:0] O_FAN_DUTY,
    input wire logic O_ALERT_PIN_OE,
    input wire logic O_LOW_RAIL_PIN_OE,
    input wire logic O_OVERHEAT_ON_TACH_PIN,
    input wire logic O_OVERHEAT_ON_FIVE_VOLT_PIN,
    input wire logic O_OVERHEAT_ACTIVE
);
    logic [7:0] c3;
    logic [7:0] c4;
    logic [7:0] m1;
    // ==========================================================
    // Shadow copies of configuration and first mask
    always @(posedge I_CLK or posedge I_RESET)
        if (I_RESET)
        begin
            c3 <= 8'h00;
            c4 <= 8'h00;
            m1 <= 8'h00;
        end
        else if (I_REG_WR)
        begin
            c3 <= (I_REG_ADDR == 8'h78) ? I_REG_WDATA : c3;
            c4 <= (I_REG_ADDR == 8'h7d) ? I_REG_WDATA : c4;
            m1 <= (I_REG_ADDR == 8'h74) ? I_REG_WDATA : m1;
        end
    // ==========================================================
    // Properties
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);
    alert_gate_a: assert property ((!c3[0]) [*2] |-> !O_ALERT_PIN_OE)
        else $error("alert pin on while off");
    rail_gate_a: assert property ((!c4[0]) [*2] |-> !O_LOW_RAIL_PIN_OE)
        else $error("rail pin on while off");
    alert_fire_a: assert property ((c3[0] && |(I_FAULT_FIRST & ~m1[6:0])) [*3] |-> O_ALERT_PIN_OE)
        else $error("unmasked fault without alert");
    tach_pin_a: assert property ((c3[1] && !c4[1]) [*2] |->
        O_OVERHEAT_ON_TACH_PIN && !O_OVERHEAT_ON_FIVE_VOLT_PIN) else $error("overheat not on tach pin");
    five_pin_a: assert property ((c3[1] && c4[1]) [*2] |->
        O_OVERHEAT_ON_FIVE_VOLT_PIN && !O_OVERHEAT_ON_TACH_PIN) else $error("overheat not on five volt pin");
    pin_off_a: assert property ((!c3[1]) [*2] |->
        !O_OVERHEAT_ON_TACH_PIN && !O_OVERHEAT_ON_FIVE_VOLT_PIN) else $error("overheat pin on while off");
    fan_pass_a: assert property (!c3[2] |=> O_FAN_DUTY == $past(I_FAN_DUTY))
        else $error("fan duty altered");
    fan_full_speed_on_overheat_a: assert property ((c3[1] && c3[2] && O_OVERHEAT_ACTIVE && !I_FAN_AUTO_MODE[0]
        && I_FAN_DUTY[7:0] != 8'h00) [*3] |-> O_FAN_DUTY[7:0] == 8'hff) else $error("fan not boosted");
    cover property (O_ALERT_PIN_OE && O_LOW_RAIL_PIN_OE);
    cover property (O_FAN_DUTY[7:0] == 8'hff);
    cover property (O_OVERHEAT_ON_FIVE_VOLT_PIN && !O_OVERHEAT_ACTIVE);
endmodule
`default_nettype wire

// file: overheat_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module overheat_host_model (
    input wire logic i_link_clk,
    input wire logic i_hold,
    output var logic o_pin
);
    // Released pin floats to its pull-up; changes only on link edges
    initial o_pin = 1'b1;
    always @(posedge i_link_clk)
        o_pin <= !i_hold;
endmodule
`default_nettype wire

// file: alert_overheat_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module alert_overheat_ctrl_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lclk = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic req = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] f2 = 8'h00;
    logic [6:0] f1 = 7'h00;
    logic [7:0] rdata, q;
    logic [23:0] fo;
    logic oe, loe, tp, fp, act, pin;
    logic ao, lo, pin5;
    logic req5 = 1'b0;
    logic [15:0] m;
    logic [14:0] v;
    wire [7:0] pins = {4'h0, tp, fp, oe, loe};
    int mismatches = 0;
    int checked = 0;
    // ==========================================================
    // Register cases: {write, offset, data, expected}
    logic [31:0] rows [16] = '{32'h00780000, 32'h007d0000, 32'h00740000, 32'h00750000, 32'h0174a500,
        32'h007400a5, 32'h01755a00, 32'h0075005a, 32'h017a0300, 32'h007a0003, 32'h0179ff00,
        32'h00790000, 32'h0141ff00, 32'h00410000, 32'h0100ff00, 32'h00000000};
    always #12.5 clk = !clk;
    initial #37 forever #100 lclk = !lclk;
    alert_overheat_ctrl #(.TICK_CYCLES(64)) dut (.I_CLK(clk), .I_RESET(rst), .I_REG_ADDR(addr),
        .I_REG_WR(wr), .I_REG_WDATA(wd), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_FAULT_FIRST(f1),
        .I_FAULT_SECOND(f2), .I_FOURTH_SPEED_INPUT(pin), .I_FIVE_VOLT_PIN(pin5), .I_FAN_DUTY(24'h300040),
        .I_FAN_AUTO_MODE(3'b100), .I_FAN_BELOW_START(3'b100), .O_FAN_DUTY(fo), .O_ALERT_PIN_OUT(ao),
        .O_ALERT_PIN_OE(oe), .O_LOW_RAIL_PIN_OUT(lo), .O_LOW_RAIL_PIN_OE(loe),
        .O_OVERHEAT_ON_TACH_PIN(tp), .O_OVERHEAT_ON_FIVE_VOLT_PIN(fp), .O_OVERHEAT_ACTIVE(act));
    overheat_host_model host (.i_link_clk(lclk), .i_hold(req), .o_pin(pin));
    overheat_host_model host5 (.i_link_clk(lclk), .i_hold(req5), .o_pin(pin5));
    // ==========================================================
    // Tasks
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        wd = d;
        wr = w;
        rd = !w;
        @(posedge clk) #1;
        wr = 1'b0;
        rd = 1'b0;
        q = rdata;
    endtask
    task st;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task hold(input int n);
        @(posedge lclk) #1 req = 1'b1;
        repeat (n) @(posedge lclk);
        #1 req = 1'b0;
        repeat (24) @(posedge clk);
    endtask
    task give_verdict;
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Saturation run dominates, about half a millisecond
    initial
    begin
        #2000000;
        mismatches++;
        give_verdict;
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        foreach (rows[i])
        begin
            acc(rows[i][24], rows[i][23:16], rows[i][15:8]);
            if (!rows[i][24])
                chk(q, rows[i][7:0]);
        end
        chk(pins, 8'h00);
        acc(1'b1, 8'h78, 8'h01);
        acc(1'b1, 8'h7d, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            m = 16'h0001 << i;
            v = 15'h0001 << (i - (i > 7));
            acc(1'b1, 8'h74, m[7:0]);
            acc(1'b1, 8'h75, m[15:8]);
            {f2, f1} = v;
            st;
            chk(pins, 8'h00);
            acc(1'b1, 8'h74, 8'h00);
            acc(1'b1, 8'h75, 8'h00);
            st;
            chk(pins, 8'h03);
            {f2, f1} = 15'h0000;
            st;
            chk(pins, 8'h03);
            acc(1'b0, 8'h41, 8'h00);
            chk(q, {|v[14:7], v[6:0]});
            acc(1'b0, 8'h42, 8'h00);
            chk(q, v[14:7]);
            st;
            chk(pins, 8'h00);
        end
        acc(1'b1, 8'h7a, 8'h00);
        acc(1'b1, 8'h75, 8'h20);
        acc(1'b1, 8'h78, 8'h03);
        st;
        chk(pins, 8'h08);
        hold(3);
        hold(17);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h02);
        hold(3);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h01);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h00);
        acc(1'b0, 8'h42, 8'h00);
        acc(1'b0, 8'h42, 8'h00);
        chk(q, 8'h00);
        acc(1'b1, 8'h78, 8'h07);
        req = 1'b1;
        repeat (4) @(posedge lclk);
        #1;
        chk(fo[7:0], 8'hff);
        chk(fo[15:8], 8'h00);
        chk(fo[23:16], 8'h30);
        chk({7'h00, act}, 8'h01);
        acc(1'b0, 8'h79, 8'h00);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h01);
        acc(1'b0, 8'h42, 8'h00);
        chk(q, 8'h20);
        chk(pins, 8'h08);
        acc(1'b0, 8'h41, 8'h00);
        chk(q, 8'h80);
        req = 1'b0;
        repeat (24) @(posedge clk);
        #1;
        chk(fo[7:0], 8'h40);
        chk({7'h00, act}, 8'h00);
        acc(1'b1, 8'h75, 8'h00);
        st;
        chk(pins, 8'h0b);
        chk({6'h00, ao, lo}, 8'h00);
        hold(2100);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'hff);
        acc(1'b1, 8'h7d, 8'h03);
        st;
        chk(pins, 8'h07);
        hold(20);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h00);
        req5 = 1'b1;
        repeat (20) @(posedge lclk);
        #1 req5 = 1'b0;
        repeat (24) @(posedge clk);
        #1;
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h02);
        acc(1'b1, 8'h7d, 8'h01);
        acc(1'b1, 8'h78, 8'h01);
        st;
        chk(pins, 8'h03);
        hold(20);
        acc(1'b0, 8'h79, 8'h00);
        chk(q, 8'h00);
        give_verdict;
    end
endmodule
bind alert_overheat_ctrl alert_overheat_ctrl_chk #(.FAN_COUNT(FAN_COUNT)) chk (.*);
`default_nettype wire
